/* spray_pkg.sv */
// Functional notes
// - One driver per nozzle feeds both air valves
// - Oil valves pulse from timing per mode
// - Oil pulse width 1.00 to 9.99 ms
// - Proportional mode sprays stroke rate times factor / 100
// - First two sprays on pulses, then free
// - Fixed rate mode ignores timing input
// - Burst mode: 1 to 63 sprays per pulse
// - Burst interval to 999 ms, floor sums open
// - Division mode sprays every Nth pulse
// - Clutch on drives air valves on
// - Clutch one-shot stretches air valve drive
// - Clutch disregard derives permit from timing
// - Low oil drives stop relay
// - Disabled state shown on inhibit relay
// - Disabled: wake after programmed pulse count
// - Function plus set toggles open-time display
// - Ten stored setting sets, recall copies
// - Up to five nozzle channels
// - Panel lock input gates panel keys
// - Test mode makes pseudo timing pulses
// - Inhibit relay closed only while enabled
package spray_pkg;
    localparam int CLK_PS = 5000;
    localparam int TICK_US = 10;
    localparam int TICK_CYC = TICK_US * 1000000 / CLK_PS;
    localparam int MIN_US = 60000000;
    localparam int TICKS_MIN = MIN_US / TICK_US;
    localparam int MS_TICKS = 1000 / TICK_US;
    localparam int FACT_SCALE = 100;
    localparam int DEB_US = 1000;
    localparam int DEB_CYC = DEB_US * 1000000 / CLK_PS;
    localparam int SHOT_MS = 100;
    localparam int SHOT_CYC = SHOT_MS * (1000000000 / CLK_PS);
    localparam logic [9:0] OPEN_MIN = 10'h064;
    localparam logic [9:0] OPEN_MAX = 10'h3E7;
    localparam logic [9:0] FACT_MIN = 10'h001;
    localparam logic [9:0] VAL_MAX = 10'h3E7;
    localparam logic [9:0] CNT_MIN = 10'h001;
    localparam logic [9:0] CNT_MAX = 10'h03F;
    localparam logic [9:0] ZERO10 = 10'h000;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_NOZ = 4'h1;
    localparam logic [3:0] OFS_OPEN0 = 4'h2;
    localparam logic [3:0] OFS_FACT = 4'h7;
    localparam logic [3:0] OFS_SPM = 4'h8;
    localparam logic [3:0] OFS_CNT = 4'h9;
    localparam logic [3:0] OFS_IVL = 4'hA;
    localparam logic [3:0] OFS_DIV = 4'hB;
    localparam logic [3:0] OFS_WAKE = 4'hC;
    localparam logic [3:0] OFS_TSPM = 4'hD;
    localparam logic [3:0] OFS_STAT = 4'hE;
    localparam logic [3:0] OFS_MEM = 4'hF;
    localparam int CTRL_EN = 0;
    localparam int CTRL_DISR = 1;
    localparam int CTRL_TEST = 2;
    localparam int CTRL_MODE = 4;
    localparam int CTRL_INH1 = 6;
    localparam int CTRL_INH2 = 7;
    localparam int MEM_STORE = 4;
    localparam int MEM_RECALL = 5;
    localparam int MEM_SETS = 10;
    localparam logic [1:0] MODE_P = 2'h0;
    localparam logic [1:0] MODE_R = 2'h1;
    localparam logic [1:0] MODE_C = 2'h2;
    localparam logic [1:0] MODE_D = 2'h3;
    localparam logic [9:0] RST_OPEN = 10'h064;
    localparam logic [9:0] RST_FACT = 10'h064;
    localparam logic [9:0] RST_SPM = 10'h03C;
    localparam logic [5:0] RST_CNT = 6'h01;
    localparam logic [9:0] RST_IVL = 10'h00A;
    localparam logic [5:0] RST_DIV = 6'h01;
    localparam logic [9:0] RST_TSPM = 10'h03C;
    localparam logic [4:0] RST_NOZ = 5'h1F;
    localparam logic [6:0] IN_IDLE = 7'h08;
    localparam int SET_W = 44;
    typedef enum logic [1:0] {P_WAIT1, P_WAIT2, P_FREE} prop_t;
endpackage : spray_pkg

/* press_spray_sequencer.sv */
module press_spray_sequencer #(
    parameter int NOZ = 5,
    parameter int DEB_CYC = spray_pkg::DEB_CYC,
    parameter int SHOT_CYC = spray_pkg::SHOT_CYC,
    parameter int PER_W = 20,
    parameter int WAKE_W = 10
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic timing_in,
    input wire logic clutch_in,
    input wire logic float_low,
    input wire logic panel_lock_n,
    input wire logic key_func,
    input wire logic key_set,
    input wire logic key_onoff,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    output logic [NOZ-1:0] oil_flow_valve_driver,
    output logic [NOZ-1:0] air_control_valve_driver,
    output logic stop_relay,
    output logic run_permit_relay,
    output logic times_hidden
);
    localparam int NIN = 7;
    localparam int DB_W = $clog2(DEB_CYC + 1);
    localparam int SH_W = $clog2(SHOT_CYC + 1);

    logic [NIN-1:0] raw;
    wire [NIN-1:0] lvl;
    logic [NIN-1:0] prev;
    logic [NIN-1:0] rise;
    logic enabled;
    logic disr, test_on, inh1, inh2;
    logic [1:0] mode;
    logic [NOZ-1:0] noz_en;
    logic [9:0] open_t [NOZ];
    logic [9:0] fact, spm, ivl, tspm;
    logic [5:0] cnt, dv;
    logic [WAKE_W-1:0] wake, wcnt;
    localparam int SET_W_L = spray_pkg::SET_W;
    logic [SET_W_L-1:0] mem [spray_pkg::MEM_SETS];
    logic [15:0] tick_c;
    logic tick;
    logic [22:0] acc_t;
    logic tp;
    logic tm_rise, lock, src_rise, src_lvl, permit;
    logic [SH_W-1:0] shot;
    spray_pkg::prop_t pst;
    logic [PER_W-1:0] per_c, period;
    logic [27:0] acc, inc, tgt, acc_sum;
    logic fire_pr, fire_c, fire_d, spray;
    logic [5:0] left;
    logic [16:0] ivl_c, ivl_t, sum_open;
    logic [5:0] dcnt;
    logic [SET_W_L-1:0] cur_set;
    logic [15:0] rmux;

    function automatic logic [9:0] clampv(input logic [15:0] v, input logic [9:0] lo,
                                          input logic [9:0] hi);
        if (v < 16'(lo)) begin
            return lo;
        end else if (v > 16'(hi)) begin
            return hi;
        end
        return v[9:0];
    endfunction : clampv

    assign raw = {key_onoff, key_set, key_func, panel_lock_n, float_low, clutch_in, timing_in};

    for (genvar g = 0; g < NIN; g++) begin : g_in
        logic s1, s2, q;
        logic [DB_W-1:0] dc;
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                s1 <= spray_pkg::IN_IDLE[g];
                s2 <= spray_pkg::IN_IDLE[g];
            end else begin
                s1 <= raw[g];
                s2 <= s1;
            end
        end
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                q <= spray_pkg::IN_IDLE[g];
                dc <= '0;
            end else if (s2 == q) begin
                dc <= '0;
            end else if (dc == DB_W'(DEB_CYC - 1)) begin
                q <= s2;
                dc <= '0;
            end else begin
                dc <= dc + 1'b1;
            end
        end
        assign lvl[g] = q;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            prev <= spray_pkg::IN_IDLE;
        end else begin
            prev <= lvl;
        end
    end

    always_comb begin
        rise = lvl & ~prev;
        lock = !lvl[3];
        tm_rise = test_on ? tp : rise[0];
        src_rise = disr ? tm_rise : rise[1];
        src_lvl = disr ? 1'b0 : lvl[1];
        permit = src_lvl | (shot != '0);
    end

    // 10 us time base
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tick_c <= '0;
            tick <= 1'b0;
        end else begin
            tick <= (tick_c == 16'(spray_pkg::TICK_CYC - 1));
            tick_c <= (tick_c == 16'(spray_pkg::TICK_CYC - 1)) ? 16'h0000 : tick_c + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            acc_t <= '0;
            tp <= 1'b0;
        end else begin
            tp <= 1'b0;
            if (!test_on) begin
                acc_t <= '0;
            end else if (tick) begin
                if (acc_t + 23'(tspm) >= 23'(spray_pkg::TICKS_MIN)) begin
                    acc_t <= acc_t + 23'(tspm) - 23'(spray_pkg::TICKS_MIN);
                    tp <= 1'b1;
                end else begin
                    acc_t <= acc_t + 23'(tspm);
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            shot <= '0;
        end else if (src_rise) begin
            shot <= SH_W'(SHOT_CYC);
        end else if (shot != '0) begin
            shot <= shot - 1'b1;
        end
    end

    // Settings, clamped on write except nozzle mask and wake; recall loads a set
    always_comb begin
        cur_set = {mode, fact, spm, cnt, ivl, dv};
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            disr <= 1'b0;
            test_on <= 1'b0;
            inh1 <= 1'b0;
            inh2 <= 1'b0;
            mode <= spray_pkg::MODE_P;
            noz_en <= NOZ'(spray_pkg::RST_NOZ);
            fact <= spray_pkg::RST_FACT;
            spm <= spray_pkg::RST_SPM;
            cnt <= spray_pkg::RST_CNT;
            ivl <= spray_pkg::RST_IVL;
            dv <= spray_pkg::RST_DIV;
            wake <= '0;
            tspm <= spray_pkg::RST_TSPM;
        end else if (wr) begin
            case (addr)
                spray_pkg::OFS_CTRL: begin
                    disr <= wdata[spray_pkg::CTRL_DISR];
                    test_on <= wdata[spray_pkg::CTRL_TEST];
                    mode <= wdata[spray_pkg::CTRL_MODE +: 2];
                    inh1 <= wdata[spray_pkg::CTRL_INH1];
                    inh2 <= wdata[spray_pkg::CTRL_INH2];
                end
                spray_pkg::OFS_NOZ: noz_en <= wdata[NOZ-1:0];
                spray_pkg::OFS_FACT: fact <= clampv(wdata, spray_pkg::FACT_MIN, spray_pkg::VAL_MAX);
                spray_pkg::OFS_SPM: spm <= clampv(wdata, spray_pkg::FACT_MIN, spray_pkg::VAL_MAX);
                spray_pkg::OFS_CNT: cnt <= 6'(clampv(wdata, spray_pkg::CNT_MIN, spray_pkg::CNT_MAX));
                spray_pkg::OFS_IVL: ivl <= clampv(wdata, spray_pkg::ZERO10, spray_pkg::VAL_MAX);
                spray_pkg::OFS_DIV: dv <= 6'(clampv(wdata, spray_pkg::CNT_MIN, spray_pkg::CNT_MAX));
                spray_pkg::OFS_WAKE: wake <= wdata[WAKE_W-1:0];
                spray_pkg::OFS_TSPM: tspm <= clampv(wdata, spray_pkg::FACT_MIN, spray_pkg::VAL_MAX);
                spray_pkg::OFS_MEM: begin
                    if (wdata[spray_pkg::MEM_RECALL] && wdata[3:0] < 4'(spray_pkg::MEM_SETS)) begin
                        {mode, fact, spm, cnt, ivl, dv} <= mem[wdata[3:0]];
                    end
                end
                default: ;
            endcase
        end
    end

    // Open time 1.00 to 9.99 ms
    for (genvar n = 0; n < NOZ; n++) begin : g_open
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                open_t[n] <= spray_pkg::RST_OPEN;
            end else if (wr && addr == spray_pkg::OFS_OPEN0 + 4'(n)) begin
                open_t[n] <= clampv(wdata, spray_pkg::OPEN_MIN, spray_pkg::OPEN_MAX);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < spray_pkg::MEM_SETS; i++) begin
                mem[i] <= '0;
            end
        end else if (wr && addr == spray_pkg::OFS_MEM && wdata[spray_pkg::MEM_STORE]
                     && wdata[3:0] < 4'(spray_pkg::MEM_SETS)) begin
            mem[wdata[3:0]] <= cur_set;
        end
    end

    // Enable: write, panel key, wake-up
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            enabled <= 1'b0;
            wcnt <= '0;
        end else begin
            if (enabled) begin
                wcnt <= '0;
            end else if (tm_rise) begin
                wcnt <= wcnt + 1'b1;
            end
            if (!enabled && tm_rise && wake != '0 && wcnt + 1'b1 == wake) begin
                enabled <= 1'b1;
                wcnt <= '0;
            end else if (wr && addr == spray_pkg::OFS_CTRL) begin
                enabled <= wdata[spray_pkg::CTRL_EN];
            end else if (rise[6] && !(lock && inh1)) begin
                enabled <= !enabled;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            times_hidden <= 1'b0;
        end else if (lvl[4] && rise[5] && !(lock && inh2)) begin
            times_hidden <= !times_hidden;
        end
    end

    always_comb begin
        inc = (mode == spray_pkg::MODE_P) ? 28'(fact) : 28'(spm);
        tgt = (mode == spray_pkg::MODE_P) ? 28'(period) * 28'(spray_pkg::FACT_SCALE)
                                          : 28'(spray_pkg::TICKS_MIN);
        acc_sum = acc + inc;
    end

    // Rate path for P and R
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pst <= spray_pkg::P_WAIT1;
            per_c <= '0;
            period <= '0;
            acc <= '0;
            fire_pr <= 1'b0;
        end else begin
            fire_pr <= 1'b0;
            if (tick && per_c != '1) begin
                per_c <= per_c + 1'b1;
            end
            if (!enabled || mode != spray_pkg::MODE_P) begin
                pst <= spray_pkg::P_WAIT1;
            end else begin
                case (pst)
                    spray_pkg::P_WAIT1: if (tm_rise) begin
                        fire_pr <= 1'b1;
                        per_c <= PER_W'(1);
                        pst <= spray_pkg::P_WAIT2;
                    end
                    spray_pkg::P_WAIT2: if (tm_rise) begin
                        fire_pr <= 1'b1;
                        period <= per_c;
                        per_c <= PER_W'(1);
                        pst <= spray_pkg::P_FREE;
                    end
                    spray_pkg::P_FREE: if (tm_rise) begin
                        period <= per_c;
                        per_c <= PER_W'(1);
                    end
                    default: pst <= spray_pkg::P_WAIT1;
                endcase
            end
            if (!enabled || mode == spray_pkg::MODE_C || mode == spray_pkg::MODE_D
                || (mode == spray_pkg::MODE_P && pst != spray_pkg::P_FREE)) begin
                acc <= '0;
            end else if (tick) begin
                if (acc_sum >= tgt) begin
                    acc <= acc_sum - tgt;
                    fire_pr <= 1'b1;
                end else begin
                    acc <= acc_sum;
                end
            end
        end
    end

    // Interval floor is sum of open times of enabled nozzles
    always_comb begin
        sum_open = '0;
        for (int i = 0; i < NOZ; i++) begin
            sum_open = sum_open + (noz_en[i] ? 17'(open_t[i]) : 17'h00000);
        end
        ivl_t = 17'(ivl) * 17'(spray_pkg::MS_TICKS);
        if (ivl_t < sum_open) begin
            ivl_t = sum_open;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            left <= '0;
            ivl_c <= '0;
            fire_c <= 1'b0;
        end else begin
            fire_c <= 1'b0;
            if (!enabled || mode != spray_pkg::MODE_C) begin
                left <= '0;
            end else if (tm_rise) begin
                fire_c <= 1'b1;
                left <= cnt - 6'h01;
                ivl_c <= '0;
            end else if (tick && left != '0) begin
                if (ivl_c + 17'h00001 >= ivl_t) begin
                    fire_c <= 1'b1;
                    left <= left - 6'h01;
                    ivl_c <= '0;
                end else begin
                    ivl_c <= ivl_c + 17'h00001;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dcnt <= '0;
            fire_d <= 1'b0;
        end else begin
            fire_d <= 1'b0;
            if (!enabled || mode != spray_pkg::MODE_D) begin
                dcnt <= '0;
            end else if (tm_rise) begin
                if (dcnt + 6'h01 >= dv) begin
                    fire_d <= 1'b1;
                    dcnt <= '0;
                end else begin
                    dcnt <= dcnt + 6'h01;
                end
            end
        end
    end

    always_comb begin
        spray = enabled & (fire_pr | fire_c | fire_d);
    end

    for (genvar n = 0; n < NOZ; n++) begin : g_noz
        logic [9:0] oc;
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                oil_flow_valve_driver[n] <= 1'b0;
                oc <= '0;
            end else if (spray && noz_en[n]) begin
                oil_flow_valve_driver[n] <= 1'b1;
                oc <= open_t[n];
            end else if (tick && oc != '0) begin
                oc <= oc - 10'h001;
                oil_flow_valve_driver[n] <= (oc != 10'h001);
            end
        end
        always_ff @(posedge clk_sys or negedge rstn) begin
            if (!rstn) begin
                air_control_valve_driver[n] <= 1'b0;
            end else begin
                air_control_valve_driver[n] <= enabled & noz_en[n] & permit;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            stop_relay <= 1'b0;
            run_permit_relay <= 1'b0;
        end else begin
            stop_relay <= lvl[2];
            run_permit_relay <= enabled;
        end
    end

    always_comb begin
        rmux = 16'h0000;
        case (addr)
            spray_pkg::OFS_CTRL: rmux = 16'({inh2, inh1, mode, 1'b0, test_on, disr, enabled});
            spray_pkg::OFS_NOZ: rmux = 16'(noz_en);
            spray_pkg::OFS_FACT: rmux = 16'(fact);
            spray_pkg::OFS_SPM: rmux = 16'(spm);
            spray_pkg::OFS_CNT: rmux = 16'(cnt);
            spray_pkg::OFS_IVL: rmux = 16'(ivl);
            spray_pkg::OFS_DIV: rmux = 16'(dv);
            spray_pkg::OFS_WAKE: rmux = 16'(wake);
            spray_pkg::OFS_TSPM: rmux = 16'(tspm);
            spray_pkg::OFS_STAT: rmux = 16'({lock, permit, times_hidden, lvl[2], enabled});
            default: begin
                for (int i = 0; i < NOZ; i++) begin
                    if (addr == spray_pkg::OFS_OPEN0 + 4'(i)) begin
                        rmux = 16'(open_t[i]);
                    end
                end
            end
        endcase
    end

    // Read data valid one cycle after strobe
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata <= '0;
        end else begin
            rdata <= rd ? rmux : 16'h0000;
        end
    end

    chk_stop_relay: assert property (@(posedge clk_sys) disable iff (!rstn)
        lvl[2] |=> stop_relay) else $error("stop relay missed low oil");
    chk_inhibit_drop: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(enabled) |-> ##1 !run_permit_relay) else $error("inhibit relay stayed");
    chk_disabled_open: assert property (@(posedge clk_sys) disable iff (!rstn)
        !enabled [*2] |-> !run_permit_relay) else $error("relay closed while disabled");
    chk_air_cause: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(air_control_valve_driver[0]) |-> $past(permit) && $past(enabled))
        else $error("air valve rose without permit");
    chk_shot_load: assert property (@(posedge clk_sys) disable iff (!rstn)
        src_rise |=> shot == SH_W'(SHOT_CYC)) else $error("one-shot not started");
    chk_oil_cause: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(oil_flow_valve_driver[0]) |-> $past(spray) && $past(noz_en[0]))
        else $error("oil pulse without spray");
    chk_rate_tick: assert property (@(posedge clk_sys) disable iff (!rstn)
        mode == spray_pkg::MODE_R && !tick |=> !fire_pr) else $error("R followed timing");
    chk_div_sync: assert property (@(posedge clk_sys) disable iff (!rstn)
        fire_d |-> $past(tm_rise) && $past(mode) == spray_pkg::MODE_D)
        else $error("division spray off pulse");
    chk_burst_start: assert property (@(posedge clk_sys) disable iff (!rstn)
        enabled && mode == spray_pkg::MODE_C && tm_rise && !wr |=> fire_c)
        else $error("burst did not start");
    chk_wake_up: assert property (@(posedge clk_sys) disable iff (!rstn)
        !enabled && tm_rise && wake != '0 && wcnt + 1'b1 == wake |=> enabled)
        else $error("wake-up missed");
endmodule : press_spray_sequencer

/* press_model.sv */
module press_model (
    input wire logic clk_sys,
    output logic timing_in,
    output logic clutch_in,
    output logic float_low
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        timing_in = 1'b0;
        clutch_in = 1'b0;
        float_low = 1'b0;
    end
    task automatic stroke();
        @(posedge clk_sys) timing_in <= 1'b1;
        repeat (20) @(posedge clk_sys);
        timing_in <= 1'b0;
        repeat (20) @(posedge clk_sys);
    endtask : stroke
    task automatic clutch_pulse(input int n);
        @(posedge clk_sys) clutch_in <= 1'b1;
        repeat (n) @(posedge clk_sys);
        clutch_in <= 1'b0;
    endtask : clutch_pulse
    task automatic set_low(input logic v);
        @(posedge clk_sys) float_low <= v;
    endtask : set_low
endmodule : press_model

/* press_spray_sequencer_tb.sv */
module press_spray_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic key_func = 1'b0;
    logic key_set = 1'b0;
    logic panel_lock_n = 1'b1;
    logic key_onoff = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    logic [4:0] oil;
    logic [4:0] air;
    logic stop_relay, run_permit_relay, times_hidden, timing_in, clutch_in, float_low;
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    always #2.5 clk_sys = ~clk_sys;
    press_model pm (.clk_sys(clk_sys), .timing_in(timing_in), .clutch_in(clutch_in),
        .float_low(float_low));
    press_spray_sequencer #(.DEB_CYC(4), .SHOT_CYC(50)) dut (.clk_sys(clk_sys), .rstn(rstn),
        .timing_in(timing_in), .clutch_in(clutch_in), .float_low(float_low),
        .panel_lock_n(panel_lock_n), .key_func(key_func), .key_set(key_set),
        .key_onoff(key_onoff),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .oil_flow_valve_driver(oil), .air_control_valve_driver(air),
        .stop_relay(stop_relay), .run_permit_relay(run_permit_relay),
        .times_hidden(times_hidden));
    task automatic give_verdict();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wait_cyc
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys) addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys) wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_sys) addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys) rd <= 1'b0;
        #1;
        chk("rdata", rdata, exp);
    endtask : rd_chk
    task automatic t_reset();
        for (int i = 2; i < 7; i++) rd_chk(4'(i), 16'h0064);
        rd_chk(spray_pkg::OFS_NOZ, 16'h001F);
        rd_chk(spray_pkg::OFS_FACT, 16'h0064);
        rd_chk(spray_pkg::OFS_CNT, 16'h0001);
        chk("run_permit", {15'h0000, run_permit_relay}, 16'h0000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_clamp();
        wr_reg(spray_pkg::OFS_OPEN0, 16'h0005);
        rd_chk(spray_pkg::OFS_OPEN0, 16'h0064);
        wr_reg(spray_pkg::OFS_OPEN0, 16'h03FF);
        rd_chk(spray_pkg::OFS_OPEN0, 16'h03E7);
        wr_reg(spray_pkg::OFS_CNT, 16'h0050);
        rd_chk(spray_pkg::OFS_CNT, 16'h003F);
        $display("test clamp done");
    endtask : t_clamp
    task automatic t_div();
        wr_reg(spray_pkg::OFS_DIV, 16'h0002);
        wr_reg(spray_pkg::OFS_CTRL, 16'h0031);
        wait_cyc(3);
        chk("run_permit", {15'h0000, run_permit_relay}, 16'h0001);
        pm.stroke();
        chk("oil", {11'h000, oil}, 16'h0000);
        pm.stroke();
        chk("oil", {11'h000, oil}, 16'h001F);
        $display("test division done");
    endtask : t_div
    task automatic t_clutch();
        pm.clutch_pulse(20);
        wait_cyc(15);
        chk("air", {11'h000, air}, 16'h001F);
        wait_cyc(60);
        chk("air", {11'h000, air}, 16'h0000);
        fork
            pm.clutch_pulse(100);
            begin
                wait_cyc(80);
                chk("air", {11'h000, air}, 16'h001F);
            end
        join
        $display("test clutch done");
    endtask : t_clutch
    task automatic t_keys();
        @(posedge clk_sys) key_func <= 1'b1;
        repeat (15) @(posedge clk_sys);
        key_set <= 1'b1;
        repeat (15) @(posedge clk_sys);
        key_set <= 1'b0;
        key_func <= 1'b0;
        wait_cyc(15);
        chk("hidden", {15'h0000, times_hidden}, 16'h0001);
        $display("test keys done");
    endtask : t_keys
    task automatic t_low_wake();
        pm.set_low(1'b1);
        wait_cyc(20);
        chk("stop", {15'h0000, stop_relay}, 16'h0001);
        pm.set_low(1'b0);
        wr_reg(spray_pkg::OFS_WAKE, 16'h0002);
        wr_reg(spray_pkg::OFS_CTRL, 16'h0030);
        wait_cyc(20);
        chk("run_permit", {15'h0000, run_permit_relay}, 16'h0000);
        pm.stroke();
        chk("run_permit", {15'h0000, run_permit_relay}, 16'h0000);
        pm.stroke();
        chk("run_permit", {15'h0000, run_permit_relay}, 16'h0001);
        $display("test low oil and wake done");
    endtask : t_low_wake
    task automatic press_onoff();
        repeat (10) @(posedge clk_sys);
        key_onoff <= 1'b1;
        repeat (10) @(posedge clk_sys);
        key_onoff <= 1'b0;
        wait_cyc(10);
    endtask : press_onoff
    task automatic t_lock();
        wr_reg(spray_pkg::OFS_CTRL, 16'h0071);
        @(posedge clk_sys) panel_lock_n <= 1'b0;
        press_onoff();
        chk("run_permit", {15'h0000, run_permit_relay}, 16'h0001);
        @(posedge clk_sys) panel_lock_n <= 1'b1;
        press_onoff();
        chk("run_permit", {15'h0000, run_permit_relay}, 16'h0000);
        $display("test panel lock done");
    endtask : t_lock
    task automatic t_prop();
        @(posedge clk_sys) rstn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        chk("oil", {11'h000, oil}, 16'h0000);
        wr_reg(spray_pkg::OFS_FACT, 16'h0020);
        wr_reg(spray_pkg::OFS_MEM, 16'h0013);
        wr_reg(spray_pkg::OFS_FACT, 16'h0050);
        wr_reg(spray_pkg::OFS_MEM, 16'h0023);
        rd_chk(spray_pkg::OFS_FACT, 16'h0020);
        wr_reg(spray_pkg::OFS_CTRL, 16'h0001);
        pm.stroke();
        chk("oil", {11'h000, oil}, 16'h001F);
        wr_reg(spray_pkg::OFS_CTRL, 16'h0003);
        pm.stroke();
        chk("air", {11'h000, air}, 16'h001F);
        $display("test proportional and memory done");
    endtask : t_prop
    initial begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        t_clamp();
        t_div();
        t_clutch();
        t_keys();
        t_low_wake();
        t_lock();
        t_prop();
        give_verdict();
    end
endmodule : press_spray_sequencer_tb
